// ### hdl/pof_fifo.sv
// Pixel FIFO with valid and ready on both sides
`default_nettype none
module pof_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign level = count_reg;
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= next_ptr(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= next_ptr(rd_ptr_reg);
      end
      count_reg <= count_next;
      // Registered so the full flag never forms a loop with the source
      in_ready <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

// ### hdl/pof_top.sv
// Pixel output formatter: strobe clock, phase shift, colour conversion
// What this block does
// - Each colour channel leaves as an 8-bit word with bit 7 as the sample's top bit.
// - Sample-to-output delay is fixed, with a longer fixed value when conversion is on.
// - With the internal clock, a phase change moves data, strobe and line sync together so their timing holds.
// - A two-bit field picks half, single, double or quarter-shifted pixel-rate strobe.
// - Every strobe comes from the internal or the external clock, locked to sampling.
// - One control bit inverts the strobe output when set.
// - The colour converter maps any input colour space to any output one by program.
// - All formatting and clock controls are writable by the host over the control port.
// - The control port answers at its one fixed device address.
`default_nettype none
module pof_top #(
  parameter int FIFO_DEPTH = pof_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus, AXI4-Lite
  input wire logic [pof_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pof_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sampled pixels in
  input wire logic pix_in_valid,
  input wire logic [7:0] pix_in_red,
  input wire logic [7:0] pix_in_green,
  input wire logic [7:0] pix_in_blue,
  input wire logic pix_in_line_sync,
  output logic pix_in_ready,
  input wire logic external_sample_clock,
  // Formatted outputs
  output logic [7:0] red_out,
  output logic [7:0] green_out,
  output logic [7:0] blue_out,
  output logic line_sync_out,
  output logic output_strobe_clock
);
  // ==========================================================
  // Control state
  logic inv_reg;
  logic [1:0] sel_reg;
  logic [1:0] phase_reg;
  logic csc_en_reg;
  logic src_ext_reg;
  logic uflow_reg;
  logic signed [11:0] coef_reg [9];
  logic signed [9:0] ofs_reg [3];
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [pof_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_coef;
  logic [7:0] wr_ofs;
  logic wr_ok;
  logic [7:0] rd_idx;
  logic [7:0] rd_coef;
  logic [7:0] rd_ofs;
  logic [31:0] rd_word;
  logic rd_ok;
  // Timing and data path
  logic [1:0] cnt_reg;
  logic [1:0] rel;
  logic ext_q_reg;
  logic ext_rise;
  logic ext_tick_reg;
  logic tick;
  logic half_reg;
  logic strobe_raw;
  logic fifo_valid;
  logic [pof_pkg::PIX_W-1:0] fifo_dout;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic [pof_pkg::PIX_W-1:0] s1_reg;
  logic [pof_pkg::PIX_W-1:0] s2_reg;
  logic [pof_pkg::PIX_W-1:0] s2_next;

  // ==========================================================
  // Colour conversion, one output channel
  function automatic logic [7:0] csc_chan(input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] c, input logic signed [11:0] k0, input logic signed [11:0] k1,
      input logic signed [11:0] k2, input logic signed [9:0] ofs);
    logic signed [23:0] acc;
    acc = 24'(k0 * $signed({1'b0, a})) + 24'(k1 * $signed({1'b0, b}))
        + 24'(k2 * $signed({1'b0, c}));
    acc = (acc >>> 8) + 24'(ofs);
    // Saturate rather than wrap, a wrap shows as bright specks
    if (acc < 0) begin
      csc_chan = 8'h00;
    end else if (acc > 24'sd255) begin
      csc_chan = 8'hff;
    end else begin
      csc_chan = acc[7:0];
    end
  endfunction

  // ==========================================================
  // Write channel
  assign wr_en = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_idx = awaddr_reg[9:2];
  assign wr_coef = wr_idx - pof_pkg::IDX_COEF0;
  assign wr_ofs = wr_idx - pof_pkg::IDX_OFS0;
  assign wr_ok = (wr_idx == pof_pkg::IDX_ID) || (wr_idx == pof_pkg::IDX_POL)
      || (wr_idx == pof_pkg::IDX_SEL) || (wr_idx == pof_pkg::IDX_PHASE)
      || (wr_idx == pof_pkg::IDX_CFG) || (wr_idx == pof_pkg::IDX_STAT)
      || (wr_coef < pof_pkg::NUM_COEF) || (wr_ofs < pof_pkg::NUM_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_hold_reg <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (!aw_hold_reg) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_hold_reg <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (!w_hold_reg) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pof_pkg::RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? pof_pkg::RESP_OKAY : pof_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inv_reg <= 1'b0;
      sel_reg <= pof_pkg::SEL_RESET;
      phase_reg <= pof_pkg::PHASE_RESET;
      csc_en_reg <= 1'b0;
      src_ext_reg <= 1'b0;
      for (int i = 0; i < 9; i++) begin
        coef_reg[i] <= (i % 4 == 0) ? pof_pkg::COEF_ONE : 12'sh000;
      end
      for (int i = 0; i < 3; i++) begin
        ofs_reg[i] <= 10'sh000;
      end
    end else if (wr_en) begin
      if (wstrb_reg[0]) begin
        if (wr_idx == pof_pkg::IDX_POL) begin
          inv_reg <= wdata_reg[pof_pkg::POL_INV_BIT];
        end
        if (wr_idx == pof_pkg::IDX_SEL) begin
          sel_reg <= wdata_reg[pof_pkg::SEL_LSB +: 2];
        end
        if (wr_idx == pof_pkg::IDX_PHASE) begin
          phase_reg <= wdata_reg[1:0];
        end
        if (wr_idx == pof_pkg::IDX_CFG) begin
          csc_en_reg <= wdata_reg[pof_pkg::CFG_CSC_BIT];
          src_ext_reg <= wdata_reg[pof_pkg::CFG_EXT_BIT];
        end
      end
      if (wr_coef < pof_pkg::NUM_COEF) begin
        if (wstrb_reg[0]) begin
          coef_reg[wr_coef[3:0]][7:0] <= wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
          coef_reg[wr_coef[3:0]][11:8] <= wdata_reg[11:8];
        end
      end
      if (wr_ofs < pof_pkg::NUM_OFS) begin
        if (wstrb_reg[0]) begin
          ofs_reg[wr_ofs[1:0]][7:0] <= wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
          ofs_reg[wr_ofs[1:0]][9:8] <= wdata_reg[9:8];
        end
      end
    end
  end

  // ==========================================================
  // Read channel
  assign rd_idx = s_axi_araddr[9:2];
  assign rd_coef = rd_idx - pof_pkg::IDX_COEF0;
  assign rd_ofs = rd_idx - pof_pkg::IDX_OFS0;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (rd_idx)
      pof_pkg::IDX_ID: rd_word = 32'(pof_pkg::CTRL_PORT_ADDR);
      pof_pkg::IDX_POL: rd_word = 32'(inv_reg);
      pof_pkg::IDX_SEL: rd_word = 32'({sel_reg, 6'h00});
      pof_pkg::IDX_PHASE: rd_word = 32'(phase_reg);
      pof_pkg::IDX_CFG: rd_word = 32'({src_ext_reg, csc_en_reg});
      pof_pkg::IDX_STAT: rd_word = 32'({uflow_reg, 8'(fifo_level), 6'h00,
          !pix_in_ready, !fifo_valid});
      default: begin
        if (rd_coef < pof_pkg::NUM_COEF) begin
          rd_word = 32'($unsigned(coef_reg[rd_coef[3:0]]));
        end else if (rd_ofs < pof_pkg::NUM_OFS) begin
          rd_word = 32'($unsigned(ofs_reg[rd_ofs[1:0]]));
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pof_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? pof_pkg::RESP_OKAY : pof_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Pixel timing
  assign ext_rise = external_sample_clock && !ext_q_reg;
  assign tick = src_ext_reg ? ext_tick_reg : (cnt_reg == phase_reg);
  assign rel = cnt_reg - phase_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 2'h0;
      ext_q_reg <= 1'b0;
      ext_tick_reg <= 1'b0;
    end else begin
      ext_q_reg <= external_sample_clock;
      ext_tick_reg <= src_ext_reg && ext_rise;
      cnt_reg <= (src_ext_reg && ext_rise) ? phase_reg : 2'(cnt_reg + 1'b1);
    end
  end

  // strobe shape from position in the pixel
  always_comb begin
    unique case (sel_reg)
      pof_pkg::SEL_HALF: strobe_raw = half_reg;
      pof_pkg::SEL_1X: strobe_raw = rel[1];
      pof_pkg::SEL_2X: strobe_raw = rel[0];
      pof_pkg::SEL_90: strobe_raw = rel[1] ^ rel[0];
    endcase
  end

  // strobe follows the phase, same edge as data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_reg <= 1'b0;
      output_strobe_clock <= 1'b0;
    end else begin
      if (rel == 2'h1) begin
        half_reg <= !half_reg;
      end
      output_strobe_clock <= strobe_raw ^ inv_reg;
    end
  end

  // ==========================================================
  // Data path
  pof_fifo #(
    .WIDTH(pof_pkg::PIX_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(pix_in_valid),
    .in_data({pix_in_line_sync, pix_in_red, pix_in_green, pix_in_blue}),
    .in_ready(pix_in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_dout),
    .out_ready(tick),
    .level(fifo_level)
  );

  // programmable matrix, any space to any space
  assign s2_next = {s1_reg[24],
      csc_chan(s1_reg[23:16], s1_reg[15:8], s1_reg[7:0], coef_reg[0], coef_reg[1],
          coef_reg[2], ofs_reg[0]),
      csc_chan(s1_reg[23:16], s1_reg[15:8], s1_reg[7:0], coef_reg[3], coef_reg[4],
          coef_reg[5], ofs_reg[1]),
      csc_chan(s1_reg[23:16], s1_reg[15:8], s1_reg[7:0], coef_reg[6], coef_reg[7],
          coef_reg[8], ofs_reg[2])};

  // fixed stages, one extra when converting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else if (tick) begin
      // Starved FIFO sends black so the stage count never slips
      s1_reg <= fifo_valid ? fifo_dout : '0;
      s2_reg <= s2_next;
    end
  end

  // one launch edge for words and sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      red_out <= 8'h00;
      green_out <= 8'h00;
      blue_out <= 8'h00;
      line_sync_out <= 1'b0;
    end else if (tick) begin
      // bit 7 carries the top bit
      {line_sync_out, red_out, green_out, blue_out} <= csc_en_reg ? s2_reg : s1_reg;
    end
  end

  // Underflow flag, a new event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uflow_reg <= 1'b0;
    end else if (tick && !fifo_valid) begin
      uflow_reg <= 1'b1;
    end else if (wr_en && wr_idx == pof_pkg::IDX_STAT && wstrb_reg[2]
        && wdata_reg[pof_pkg::STAT_UFLOW_BIT]) begin
      uflow_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  sequence s_pop_bypass;
    tick && fifo_valid && !csc_en_reg && !src_ext_reg ##1 (!wr_en)[*4];
  endsequence
  sequence s_pop_csc;
    tick && fifo_valid && csc_en_reg && !src_ext_reg ##1 (!wr_en)[*8];
  endsequence

  a_bypass_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    s_pop_bypass |=> red_out == $past(fifo_dout[23:16], 5)
      && line_sync_out == $past(fifo_dout[24], 5))
    else $error("bypass latency wrong");
  a_msb_order: assert property (@(posedge aclk) disable iff (!aresetn)
    s_pop_bypass |=> blue_out[7] == $past(fifo_dout[7], 5) && green_out[7] == $past(fifo_dout[15], 5))
    else $error("output bit order wrong");
  a_csc_result: assert property (@(posedge aclk) disable iff (!aresetn)
    s_pop_csc |=> red_out == csc_chan($past(fifo_dout[23:16], 9), $past(fifo_dout[15:8], 9),
      $past(fifo_dout[7:0], 9), coef_reg[0], coef_reg[1], coef_reg[2], ofs_reg[0]))
    else $error("converted pixel wrong or late");
  a_strobe_shift: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && sel_reg == pof_pkg::SEL_1X && !src_ext_reg && !wr_en ##1 (!wr_en)[*3]
      |-> output_strobe_clock == !inv_reg && $past(output_strobe_clock, 2) == inv_reg)
    else $error("strobe not aligned to launch");
  a_strobe_double: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_reg == pof_pkg::SEL_2X && !src_ext_reg && !wr_en ##1 !wr_en
      |=> output_strobe_clock != $past(output_strobe_clock))
    else $error("double rate strobe not toggling");
  a_strobe_half: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_reg == pof_pkg::SEL_HALF && !src_ext_reg ##0 (!wr_en)[*6]
      |-> output_strobe_clock != $past(output_strobe_clock, 4))
    else $error("half rate strobe period wrong");
  a_ext_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    src_ext_reg && ext_rise && !wr_en |=> tick && cnt_reg == phase_reg)
    else $error("external edge did not start a pixel");
  a_strobe_invert: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && sel_reg == pof_pkg::SEL_1X && !wr_en |=> output_strobe_clock == inv_reg)
    else $error("strobe polarity wrong");
  a_control_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && wr_idx == pof_pkg::IDX_SEL && wstrb_reg[0]
      |=> sel_reg == $past(wdata_reg[7:6]) && s_axi_bvalid && s_axi_bresp == pof_pkg::RESP_OKAY)
    else $error("strobe select write lost");
  a_port_address: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == pof_pkg::IDX_ID
      |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0098)
    else $error("port address read wrong");
  a_common_launch: assert property (@(posedge aclk) disable iff (!aresetn)
    !tick |=> $stable(red_out) && $stable(green_out) && $stable(blue_out)
      && $stable(line_sync_out))
    else $error("outputs moved off the launch edge");
endmodule
`default_nettype wire

// ### include/pof_pkg.sv
// Constants shared by the pixel output clock formatter
`default_nettype none
package pof_pkg;
  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_ID = 8'h00;
  localparam logic [7:0] IDX_POL = 8'h24;
  localparam logic [7:0] IDX_SEL = 8'h25;
  localparam logic [7:0] IDX_PHASE = 8'h30;
  localparam logic [7:0] IDX_CFG = 8'h31;
  localparam logic [7:0] IDX_STAT = 8'h32;
  localparam logic [7:0] IDX_COEF0 = 8'h40;
  localparam logic [7:0] IDX_OFS0 = 8'h49;
  localparam logic [7:0] NUM_COEF = 8'h09;
  localparam logic [7:0] NUM_OFS = 8'h03;
  localparam int ADDR_W = 10;
  // ==========================================================
  // Field positions
  localparam int POL_INV_BIT = 0;
  localparam int SEL_LSB = 6;
  localparam int CFG_CSC_BIT = 0;
  localparam int CFG_EXT_BIT = 1;
  localparam int STAT_UFLOW_BIT = 16;
  localparam int STAT_LEVEL_LSB = 8;
  // ==========================================================
  // Strobe choices
  localparam logic [1:0] SEL_HALF = 2'h0;
  localparam logic [1:0] SEL_1X = 2'h1;
  localparam logic [1:0] SEL_2X = 2'h2;
  localparam logic [1:0] SEL_90 = 2'h3;
  // ==========================================================
  // Reset values and fixed figures
  localparam logic [7:0] CTRL_PORT_ADDR = 8'h98;
  localparam logic [1:0] SEL_RESET = SEL_1X;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic signed [11:0] COEF_ONE = 12'sh100;
  localparam int COEF_W = 12;
  localparam int OFS_W = 10;
  localparam int PIX_W = 25;
  localparam int FIFO_DEPTH = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### sim/pof_sink.sv
// Downstream capture model clocked by the strobe output
`default_nettype none
module pof_sink (
  // Strobe and lines to capture
  input wire logic strobe,
  input wire logic [24:0] word_in,
  // Last captured word
  output logic [24:0] word_cap
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Capture on the strobe, not on aclk, as real logic would
  // strobe captures word
  always @(posedge strobe) begin
    word_cap <= word_in;
  end
endmodule
`default_nettype wire

// ### sim/pof_top_tb.sv
// Self-checking bench for the pixel output formatter
`default_nettype none
module pof_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pvalid, psync, ext_clk;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, lfsr;
  logic [7:0] pr, pg, pb;
  wire logic awready, wready, bvalid, arready, rvalid, pready, sync_o, strobe;
  wire logic [31:0] rdata;
  wire logic [1:0] bresp, rresp;
  wire logic [7:0] ro, go, bo;
  wire logic [24:0] cap;
  logic [24:0] exp_q[$];
  logic [24:0] prev_w;
  logic [1:0] ext_div;
  logic inv, ext, swap, full_seen, last;
  int fail_count, cmp_count, n;
  int exp_n[4] = '{10, 20, 40, 20};
  // ==========
  // Design and far-side model
  pof_top #(.FIFO_DEPTH(8)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pix_in_valid(pvalid), .pix_in_red(pr), .pix_in_green(pg), .pix_in_blue(pb),
    .pix_in_line_sync(psync), .pix_in_ready(pready), .external_sample_clock(ext_clk),
    .red_out(ro), .green_out(go), .blue_out(bo), .line_sync_out(sync_o),
    .output_strobe_clock(strobe));
  pof_sink sink_u (.strobe(strobe), .word_in({sync_o, ro, go, bo}), .word_cap(cap));
  // ==========
  // Clocks
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // External pixel clock at a quarter of aclk
  always @(posedge aclk) begin
    ext_div <= (aresetn === 1'b1) ? 2'(ext_div + 2'h1) : 2'h0;
    ext_clk <= (aresetn === 1'b1) && ext_div[1];
  end
  // ==========
  // Helpers
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {bvalid, bresp}, {1'b1, er});
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", {rvalid, rresp}, {1'b1, er});
    chk("rdata", rdata, ed);
  endtask
  // Source holds each pixel until taken, noting the expected word
  task automatic push(input logic [24:0] p);
    {psync, pr, pg, pb} <= p;
    pvalid <= 1'b1;
    @(posedge aclk);
    while (pready !== 1'b1) begin
      full_seen = 1'b1;
      @(posedge aclk);
    end
    exp_q.push_back(swap ? {p[24], p[7:0], p[15:8], p[23:16]} : p);
  endtask
  // ==========
  // Output watcher: each new word is checked against the oldest note
  always @(negedge aclk) begin
    if (aresetn === 1'b1 && {sync_o, ro, go, bo} !== prev_w && {sync_o, ro, go, bo} !== 0) begin
      chk("pixel", {sync_o, ro, go, bo}, exp_q.size() > 0 ? exp_q.pop_front() : 25'h0);
      if (!ext) chk("strobe", strobe, inv);
    end
    prev_w <= {sync_o, ro, go, bo};
  end
  // ==========
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pvalid, psync} = 8'h00;
    {awaddr, araddr, wdata, pr, pg, pb} = 0;
    {inv, ext, swap, full_seen} = 0;
    lfsr = 32'h0000_c27c;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pof_pkg::IDX_ID, 32'h0000_0098, pof_pkg::RESP_OKAY);
    rd(pof_pkg::IDX_SEL, 32'h0000_0040, pof_pkg::RESP_OKAY);
    rd(8'h10, 32'h0000_0000, pof_pkg::RESP_SLVERR);
    wr(8'h10, 32'h0000_00ff, pof_pkg::RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      wr(pof_pkg::IDX_SEL, {24'h0, i[1:0], 6'h0}, pof_pkg::RESP_OKAY);
      wr(pof_pkg::IDX_POL, {31'h0, i[2]}, pof_pkg::RESP_OKAY);
      rd(pof_pkg::IDX_SEL, {24'h0, i[1:0], 6'h0}, pof_pkg::RESP_OKAY);
      @(negedge aclk);
      last = strobe;
      n = 0;
      repeat (40) begin
        @(negedge aclk);
        if (strobe !== last) n++;
        last = strobe;
      end
      chk("strobe edges", n, exp_n[i[1:0]]);
    end
    wr(pof_pkg::IDX_SEL, 32'h0000_0040, pof_pkg::RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      inv = k[0];
      ext = (k == 2);
      swap = (k == 3);
      wr(pof_pkg::IDX_POL, {31'h0, inv}, pof_pkg::RESP_OKAY);
      wr(pof_pkg::IDX_PHASE, k, pof_pkg::RESP_OKAY);
      // Swap red and blue through the converter
      for (int c = 0; c < 9; c++) begin
        if (swap) wr(pof_pkg::IDX_COEF0 + c[7:0], (c inside {2, 4, 6}) ? 32'h0000_0100 : 0,
          pof_pkg::RESP_OKAY);
      end
      wr(pof_pkg::IDX_CFG, {30'h0, ext, k[0]}, pof_pkg::RESP_OKAY);
      for (int j = 1; j < 13; j++) begin
        lfsr = next_rand(lfsr);
        push({lfsr[16], j[7:0], lfsr[15:0]});
      end
      pvalid <= 1'b0;
      repeat (300) begin
        @(posedge aclk);
        if (exp_q.size() == 0) break;
      end
      chk("drained", exp_q.size(), 0);
      if (k == 0) begin
        repeat (2) @(posedge aclk);
        chk("capture", cap, {lfsr[16], 8'h0c, lfsr[15:0]});
        rd(pof_pkg::IDX_STAT, 32'h0001_0001, pof_pkg::RESP_OKAY);
      end
    end
    chk("fifo refused", full_seen, 1);
    stop_test();
  end
  // ==========
  // Watchdog, over thirty times the expected run
  initial begin
    #3_000_000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
